// *** core/pdcm_top.sv ***
/*
 * Configuration-port word bank for the quad PLL, channel PLL and output-clock dividers.
 * Assumes the port is driven on ref_clk_i by a single agent; every access is answered
 * with a ready pulse one cycle after the enable.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pdcm_map.svh"

module pdcm_top (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic cfg_en_i,
    input wire logic cfg_we_i,
    input wire logic [`PDCM_ADDR_W-1:0] cfg_addr_i,
    input wire logic [`PDCM_DATA_W-1:0] cfg_di_i,
    output logic [`PDCM_DATA_W-1:0] cfg_do_o,
    output logic cfg_rdy_o,
    output pdcm_pkg::pdcm_raw_t raw_o,
    output pdcm_pkg::pdcm_setting_t settings_o
);

    //--------------------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------------------
    logic [`PDCM_DATA_W-1:0] quad_pll_config_low;
    logic [`PDCM_QUAD_HIGH_W-1:0] quad_pll_config_high;
    logic [4:0] quad_pll_ref_divider;
    logic [`PDCM_QUAD_FB_MSB:0] quad_pll_feedback_divider;
    logic quad_pll_feedback_ratio;
    logic [`PDCM_CH_LOW_W-1:0] channel_pll_config_low;
    logic [`PDCM_DATA_W-1:0] channel_pll_config_high;
    logic [4:0] channel_pll_ref_divider;
    logic channel_pll_feedback_four_five;
    logic [`PDCM_CH_FB_MSB:0] channel_pll_feedback_divider;
    logic [2:0] tx_output_divider;
    logic [2:0] rx_output_divider;
    logic wr;
    logic rd;
    logic [`PDCM_DATA_W-1:0] read_word;
    pdcm_pkg::pdcm_setting_t next_settings;

    // Access qualifiers for the taken edge.
    assign wr = cfg_en_i && cfg_we_i;
    assign rd = cfg_en_i && !cfg_we_i;

    //--------------------------------------------------------------------------
    // Word writes
    //--------------------------------------------------------------------------
    // Low half of the quad PLL configuration value.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quad_pll_config_low <= `PDCM_RST_QUAD_LOW;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_QUAD_LOW) begin
            quad_pll_config_low <= cfg_di_i;
        end
    end

    // Word 0x33 shares the reference divider with the upper configuration bits.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quad_pll_config_high <= `PDCM_RST_QUAD_HIGH;
            quad_pll_ref_divider <= `PDCM_RST_REF;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_QUAD_HIGH) begin
            quad_pll_config_high <= cfg_di_i[`PDCM_QUAD_HIGH_MSB:0];
            quad_pll_ref_divider <= cfg_di_i[`PDCM_QUAD_REF_MSB:`PDCM_QUAD_REF_LSB];
        end
    end

    // Quad PLL feedback divider, stored as written.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quad_pll_feedback_divider <= `PDCM_RST_QUAD_FB;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_QUAD_FB) begin
            quad_pll_feedback_divider <= cfg_di_i[`PDCM_QUAD_FB_MSB:0];
        end
    end

    // Quad PLL feedback ratio flag.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quad_pll_feedback_ratio <= `PDCM_RST_RATIO;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_QUAD_RATIO) begin
            quad_pll_feedback_ratio <= cfg_di_i[`PDCM_QUAD_RATIO_BIT];
        end
    end

    // Channel PLL configuration value, low byte in the upper half of its word.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            channel_pll_config_low <= `PDCM_RST_CH_LOW;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_CH_LOW) begin
            channel_pll_config_low <= cfg_di_i[`PDCM_CH_LOW_MSB:`PDCM_CH_LOW_LSB];
        end
    end

    // Channel PLL configuration value, bits 23:8.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            channel_pll_config_high <= `PDCM_RST_CH_HIGH;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_CH_HIGH) begin
            channel_pll_config_high <= cfg_di_i;
        end
    end

    // Channel PLL divider word with three fields.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            channel_pll_ref_divider <= `PDCM_RST_REF;
            channel_pll_feedback_four_five <= `PDCM_RST_CH_45;
            channel_pll_feedback_divider <= `PDCM_RST_CH_FB;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_CH_DIV) begin
            channel_pll_ref_divider <= cfg_di_i[`PDCM_CH_REF_MSB:`PDCM_CH_REF_LSB];
            channel_pll_feedback_four_five <= cfg_di_i[`PDCM_CH_45_BIT];
            channel_pll_feedback_divider <= cfg_di_i[`PDCM_CH_FB_MSB:0];
        end
    end

    // Output-clock dividers for both directions share one word.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_output_divider <= `PDCM_RST_OUT_DIV;
            rx_output_divider <= `PDCM_RST_OUT_DIV;
        end else if (wr && cfg_addr_i == `PDCM_ADDR_OUT_DIV) begin
            tx_output_divider <= cfg_di_i[`PDCM_TX_MSB:`PDCM_TX_LSB];
            rx_output_divider <= cfg_di_i[`PDCM_RX_MSB:`PDCM_RX_LSB];
        end
    end

    //--------------------------------------------------------------------------
    // Read-back and port answer
    //--------------------------------------------------------------------------
    // Every field reads back as stored so that partial updates can preserve neighbours;
    // unused bits and unmapped words read as zero.
    always_comb begin
        read_word = '0;
        unique case (cfg_addr_i)
            `PDCM_ADDR_QUAD_LOW: read_word = quad_pll_config_low;
            `PDCM_ADDR_QUAD_HIGH: begin
                read_word[`PDCM_QUAD_REF_MSB:`PDCM_QUAD_REF_LSB] = quad_pll_ref_divider;
                read_word[`PDCM_QUAD_HIGH_MSB:0] = quad_pll_config_high;
            end
            `PDCM_ADDR_QUAD_FB: read_word[`PDCM_QUAD_FB_MSB:0] = quad_pll_feedback_divider;
            `PDCM_ADDR_QUAD_RATIO: read_word[`PDCM_QUAD_RATIO_BIT] = quad_pll_feedback_ratio;
            `PDCM_ADDR_CH_LOW:
                read_word[`PDCM_CH_LOW_MSB:`PDCM_CH_LOW_LSB] = channel_pll_config_low;
            `PDCM_ADDR_CH_HIGH: read_word = channel_pll_config_high;
            `PDCM_ADDR_CH_DIV: begin
                read_word[`PDCM_CH_REF_MSB:`PDCM_CH_REF_LSB] = channel_pll_ref_divider;
                read_word[`PDCM_CH_45_BIT] = channel_pll_feedback_four_five;
                read_word[`PDCM_CH_FB_MSB:0] = channel_pll_feedback_divider;
            end
            `PDCM_ADDR_OUT_DIV: begin
                read_word[`PDCM_TX_MSB:`PDCM_TX_LSB] = tx_output_divider;
                read_word[`PDCM_RX_MSB:`PDCM_RX_LSB] = rx_output_divider;
            end
            default: read_word = '0;
        endcase
    end

    // Read data is captured at the taken edge and held until the next read.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_do_o <= '0;
        end else if (rd) begin
            cfg_do_o <= read_word;
        end
    end

    // Ready pulses once, one cycle after each enable, for reads and writes alike.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_rdy_o <= 1'b0;
        end else begin
            cfg_rdy_o <= cfg_en_i;
        end
    end

    //--------------------------------------------------------------------------
    // Settings towards the PLLs
    //--------------------------------------------------------------------------
    // The split configuration values are joined into whole fields.
    assign raw_o.quad_pll_config = {quad_pll_config_high, quad_pll_config_low};
    assign raw_o.quad_pll_ref_divider = quad_pll_ref_divider;
    assign raw_o.quad_pll_feedback_divider = quad_pll_feedback_divider;
    assign raw_o.quad_pll_feedback_ratio = quad_pll_feedback_ratio;
    assign raw_o.channel_pll_config = {channel_pll_config_high, channel_pll_config_low};
    assign raw_o.channel_pll_ref_divider = channel_pll_ref_divider;
    assign raw_o.channel_pll_feedback_four_five = channel_pll_feedback_four_five;
    assign raw_o.channel_pll_feedback_divider = channel_pll_feedback_divider;
    assign raw_o.tx_output_divider = tx_output_divider;
    assign raw_o.rx_output_divider = rx_output_divider;

    pdcm_decode u_decode (
        .raw_i(raw_o),
        .setting_o(next_settings)
    );

    // Decoded settings are registered so the PLL side sees glitch-free values.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            settings_o <= '0;
        end else begin
            settings_o <= next_settings;
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence write_word_s(logic [`PDCM_ADDR_W-1:0] a);
        cfg_en_i && cfg_we_i && cfg_addr_i == a;
    endsequence

    sequence read_word_s(logic [`PDCM_ADDR_W-1:0] a);
        cfg_en_i && !cfg_we_i && cfg_addr_i == a;
    endsequence

    port_answer_a: assert property (cfg_en_i |=> cfg_rdy_o ##1 (cfg_rdy_o == $past(cfg_en_i)))
        else $error("Ready did not follow the enable by one cycle.");

    ready_cause_a: assert property (cfg_rdy_o |-> $past(cfg_en_i))
        else $error("Ready pulsed without an access.");

    out_div_store_a: assert property (write_word_s(`PDCM_ADDR_OUT_DIV) |=>
        (tx_output_divider == $past(cfg_di_i[`PDCM_TX_MSB:`PDCM_TX_LSB])) &&
        (rx_output_divider == $past(cfg_di_i[`PDCM_RX_MSB:`PDCM_RX_LSB])))
        else $error("Output divider word not stored in its fields.");

    out_div_decode_a: assert property ((tx_output_divider <= `PDCM_OUT_CODE_MAX) |=>
        settings_o.tx_divide == (5'h01 << $past(tx_output_divider)))
        else $error("Transmit divide value does not match its code.");

    band_select_a: assert property (##1 settings_o.quad_pll_lower_band ==
        $past(raw_o.quad_pll_config[`PDCM_BAND_BIT]))
        else $error("Band selection does not follow configuration bit six.");

    quad_split_a: assert property (write_word_s(`PDCM_ADDR_QUAD_HIGH) ##1
        read_word_s(`PDCM_ADDR_QUAD_HIGH) |=> cfg_rdy_o &&
        cfg_do_o[`PDCM_QUAD_HIGH_MSB:0] == $past(cfg_di_i[`PDCM_QUAD_HIGH_MSB:0], 2) &&
        raw_o.quad_pll_config[`PDCM_QUAD_CONF_W-1:`PDCM_QUAD_SPLIT] ==
        cfg_do_o[`PDCM_QUAD_HIGH_MSB:0])
        else $error("Upper quad configuration bits not read back from word 0x33.");

    quad_ref_decode_a: assert property ((quad_pll_ref_divider == `PDCM_REF_CODE_1) |=>
        settings_o.quad_pll_ref_value == 3'h1)
        else $error("Quad reference code 16 did not decode to divide by one.");

    channel_word_a: assert property (write_word_s(`PDCM_ADDR_CH_DIV) |=>
        channel_pll_ref_divider == $past(cfg_di_i[`PDCM_CH_REF_MSB:`PDCM_CH_REF_LSB]) &&
        channel_pll_feedback_four_five == $past(cfg_di_i[`PDCM_CH_45_BIT]) &&
        channel_pll_feedback_divider == $past(cfg_di_i[`PDCM_CH_FB_MSB:0]))
        else $error("Channel divider word not stored in its fields.");

    four_five_a: assert property (channel_pll_feedback_four_five |=>
        settings_o.channel_pll_four_five_factor == 3'h5)
        else $error("Four/five flag set but factor is not five.");

    ratio_check_a: assert property ((quad_pll_feedback_divider == `PDCM_FB_RATIO_EXCEPT &&
        quad_pll_feedback_ratio) |=> settings_o.quad_setting_error)
        else $error("Ratio flag set with feedback 66 was not flagged.");

    unmapped_read_a: assert property (read_word_s(`PDCM_ADDR_CH_LOW + 9'h004) |=>
        cfg_do_o == '0)
        else $error("Unmapped word did not read as zero.");

endmodule // pdcm_top
`default_nettype wire

// *** core/pdcm_map.svh ***
/*
 * Constants of the PLL divider configuration map: word addresses, field positions,
 * reset values and divider encodings.
 * Assumes it is included by its bare name; it holds definitions only.
 */
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
// Overview of operation
// - Word 0x88: TX bits 6:4, RX bits 2:0.
// - Quad config: 15:0 at 0x32, 26:16 at 0x33.
// - Quad reference divider in 0x33 bits 15:11.
// - Word 0x5E: reference, four/five, second feedback.
`ifndef PDCM_MAP_SVH
`define PDCM_MAP_SVH

//------------------------------------------------------------------------------
// Port geometry and word addresses
//------------------------------------------------------------------------------
`define PDCM_ADDR_W 9
`define PDCM_DATA_W 16
`define PDCM_ADDR_QUAD_LOW 9'h032
`define PDCM_ADDR_QUAD_HIGH 9'h033
`define PDCM_ADDR_QUAD_FB 9'h036
`define PDCM_ADDR_QUAD_RATIO 9'h037
`define PDCM_ADDR_CH_LOW 9'h05C
`define PDCM_ADDR_CH_HIGH 9'h05D
`define PDCM_ADDR_CH_DIV 9'h05E
`define PDCM_ADDR_OUT_DIV 9'h088

//------------------------------------------------------------------------------
// Field positions and widths
//------------------------------------------------------------------------------
`define PDCM_QUAD_CONF_W 27
`define PDCM_QUAD_HIGH_W 11
`define PDCM_QUAD_HIGH_MSB 10
`define PDCM_QUAD_SPLIT 16
`define PDCM_QUAD_REF_MSB 15
`define PDCM_QUAD_REF_LSB 11
`define PDCM_QUAD_FB_MSB 9
`define PDCM_QUAD_RATIO_BIT 6
`define PDCM_BAND_BIT 6
`define PDCM_CH_CONF_W 24
`define PDCM_CH_LOW_W 8
`define PDCM_CH_LOW_MSB 15
`define PDCM_CH_LOW_LSB 8
`define PDCM_CH_REF_MSB 12
`define PDCM_CH_REF_LSB 8
`define PDCM_CH_45_BIT 7
`define PDCM_CH_FB_MSB 6
`define PDCM_TX_MSB 6
`define PDCM_TX_LSB 4
`define PDCM_RX_MSB 2
`define PDCM_RX_LSB 0

//------------------------------------------------------------------------------
// Reset values
//------------------------------------------------------------------------------
`define PDCM_RST_QUAD_LOW 16'h0000
`define PDCM_RST_QUAD_HIGH 11'h000
`define PDCM_RST_REF 5'h10
`define PDCM_RST_QUAD_FB 10'h010
`define PDCM_RST_RATIO 1'h1
`define PDCM_RST_CH_LOW 8'h00
`define PDCM_RST_CH_HIGH 16'h0000
`define PDCM_RST_CH_45 1'h0
`define PDCM_RST_CH_FB 7'h10
`define PDCM_RST_OUT_DIV 3'h0

//------------------------------------------------------------------------------
// Divider encodings
//------------------------------------------------------------------------------
`define PDCM_REF_CODE_1 5'h10
`define PDCM_REF_CODE_2 5'h00
`define PDCM_REF_CODE_3 5'h01
`define PDCM_REF_CODE_4 5'h02
`define PDCM_CHFB_CODE_1 7'h10
`define PDCM_CHFB_CODE_2 7'h00
`define PDCM_CHFB_CODE_3 7'h01
`define PDCM_CHFB_CODE_4 7'h02
`define PDCM_CHFB_CODE_5 7'h03
`define PDCM_OUT_CODE_MAX 3'h4
`define PDCM_FB_RATIO_EXCEPT 10'h042

`endif

// *** core/pdcm_pkg.sv ***
/*
 * Types of the PLL divider configuration map: raw stored fields and decoded settings.
 * Assumes pdcm_map.svh is on the include path.
 */
`include "pdcm_map.svh"

package pdcm_pkg;

    // Fields exactly as held in the configuration words.
    typedef struct packed {
        logic [`PDCM_QUAD_CONF_W-1:0] quad_pll_config;
        logic [4:0] quad_pll_ref_divider;
        logic [`PDCM_QUAD_FB_MSB:0] quad_pll_feedback_divider;
        logic quad_pll_feedback_ratio;
        logic [`PDCM_CH_CONF_W-1:0] channel_pll_config;
        logic [4:0] channel_pll_ref_divider;
        logic channel_pll_feedback_four_five;
        logic [`PDCM_CH_FB_MSB:0] channel_pll_feedback_divider;
        logic [2:0] tx_output_divider;
        logic [2:0] rx_output_divider;
    } pdcm_raw_t;

    // Divide values as the PLLs apply them; zero marks an illegal code, except the quad feedback value, which passes through as stored.
    typedef struct packed {
        logic quad_pll_lower_band;
        logic [2:0] quad_pll_ref_value;
        logic [`PDCM_QUAD_FB_MSB:0] quad_pll_feedback_value;
        logic [1:0] channel_pll_ref_value;
        logic [2:0] channel_pll_four_five_factor;
        logic [2:0] channel_pll_feedback_value;
        logic [4:0] tx_divide;
        logic [4:0] rx_divide;
        logic quad_setting_error;
        logic channel_setting_error;
    } pdcm_setting_t;

endpackage

// *** core/pdcm_decode.sv ***
/*
 * Decoder from stored divider codes to divide values, with legality checks.
 * Assumes raw fields come from registers on the same clock; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pdcm_map.svh"

module pdcm_decode (
    input wire pdcm_pkg::pdcm_raw_t raw_i,
    output pdcm_pkg::pdcm_setting_t setting_o
);

    logic fb_listed;
    logic ratio_bad;

    // Output divider codes 0..4 select 1,2,4,8,16 for whichever PLL drives the lane.
    always_comb begin
        setting_o = '0;
        setting_o.quad_pll_lower_band = raw_i.quad_pll_config[`PDCM_BAND_BIT];
        setting_o.quad_pll_feedback_value = raw_i.quad_pll_feedback_divider;
        if (raw_i.tx_output_divider <= `PDCM_OUT_CODE_MAX) begin
            setting_o.tx_divide = 5'h01 << raw_i.tx_output_divider;
        end
        if (raw_i.rx_output_divider <= `PDCM_OUT_CODE_MAX) begin
            setting_o.rx_divide = 5'h01 << raw_i.rx_output_divider;
        end
        // Quad reference divider codes 16,0,1,2 mean 1..4.
        unique case (raw_i.quad_pll_ref_divider)
            `PDCM_REF_CODE_1: setting_o.quad_pll_ref_value = 3'h1;
            `PDCM_REF_CODE_2: setting_o.quad_pll_ref_value = 3'h2;
            `PDCM_REF_CODE_3: setting_o.quad_pll_ref_value = 3'h3;
            `PDCM_REF_CODE_4: setting_o.quad_pll_ref_value = 3'h4;
            default: setting_o.quad_pll_ref_value = 3'h0;
        endcase
        // Channel reference divider codes 16,0 mean 1,2.
        unique case (raw_i.channel_pll_ref_divider)
            `PDCM_REF_CODE_1: setting_o.channel_pll_ref_value = 2'h1;
            `PDCM_REF_CODE_2: setting_o.channel_pll_ref_value = 2'h2;
            default: setting_o.channel_pll_ref_value = 2'h0;
        endcase
        setting_o.channel_pll_four_five_factor =
            raw_i.channel_pll_feedback_four_five ? 3'h5 : 3'h4;
        unique case (raw_i.channel_pll_feedback_divider)
            `PDCM_CHFB_CODE_1: setting_o.channel_pll_feedback_value = 3'h1;
            `PDCM_CHFB_CODE_2: setting_o.channel_pll_feedback_value = 3'h2;
            `PDCM_CHFB_CODE_3: setting_o.channel_pll_feedback_value = 3'h3;
            `PDCM_CHFB_CODE_4: setting_o.channel_pll_feedback_value = 3'h4;
            `PDCM_CHFB_CODE_5: setting_o.channel_pll_feedback_value = 3'h5;
            default: setting_o.channel_pll_feedback_value = 3'h0;
        endcase
        // Illegal combinations are flagged, never corrected, so software sees its slip.
        setting_o.quad_setting_error = !fb_listed || ratio_bad ||
            (setting_o.quad_pll_ref_value == 3'h0) ||
            (setting_o.tx_divide == 5'h00) || (setting_o.rx_divide == 5'h00);
        setting_o.channel_setting_error = (setting_o.channel_pll_ref_value == 2'h0) ||
            (setting_o.channel_pll_feedback_value == 3'h0);
    end

    // Only the listed feedback values are supported.
    always_comb begin
        unique case (raw_i.quad_pll_feedback_divider)
            10'h010, 10'h014, 10'h020, 10'h028, 10'h040, 10'h042, 10'h050, 10'h064:
                fb_listed = 1'b1;
            default: fb_listed = 1'b0;
        endcase
    end

    // The ratio flag is zero exactly when the feedback value is 66.
    assign ratio_bad = raw_i.quad_pll_feedback_ratio ==
        (raw_i.quad_pll_feedback_divider == `PDCM_FB_RATIO_EXCEPT);

endmodule // pdcm_decode
`default_nettype wire

// *** verification/pdcm_top_tb.sv ***
/*
 * Self-checking bench for the PLL divider configuration word bank.
 * Assumes pdcm_map.svh on the include path and a ready pulse one cycle after each enable.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pdcm_map.svh"
module pdcm_top_tb;
    //--------------------------------------------------------------------------
    // Signals and tables
    //--------------------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn, en, we, rdy;
    logic [8:0] addr;
    logic [15:0] di, dout;
    pdcm_pkg::pdcm_raw_t raw;
    pdcm_pkg::pdcm_setting_t set;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    int k;
    localparam logic [8:0] RA [9] = '{9'h032, 9'h033, 9'h036, 9'h037, 9'h05C, 9'h05D,
                                      9'h05E, 9'h088, 9'h100};
    localparam logic [15:0] RV [9] = '{16'h0000, 16'h8000, 16'h0010, 16'h0040, 16'h0000,
                                       16'h0000, 16'h1010, 16'h0000, 16'h0000};
    localparam logic [9:0] FB [8] = '{10'h010, 10'h014, 10'h020, 10'h028, 10'h040, 10'h042,
                                      10'h050, 10'h064};
    localparam logic [4:0] QREF [4] = '{5'h10, 5'h00, 5'h01, 5'h02};
    localparam logic [6:0] CFB [5] = '{7'h10, 7'h00, 7'h01, 7'h02, 7'h03};

    pdcm_top dut_u (.ref_clk_i(clk), .rstn_i(rstn), .cfg_en_i(en), .cfg_we_i(we),
        .cfg_addr_i(addr), .cfg_di_i(di), .cfg_do_o(dout), .cfg_rdy_o(rdy), .raw_o(raw),
        .settings_o(set));

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    //--------------------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One port access; the ready pulse must show exactly one cycle after the enable.
    task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        #2;
        en = 1'b1;
        we = w;
        addr = a;
        di = d;
        @(posedge clk);
        #2;
        en = 1'b0;
        chk({31'h0, rdy}, 32'h1);
    endtask

    // Reads a word and compares it.
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk({16'h0, dout}, {16'h0, e});
    endtask

    // Writes a word and reads it back at the very next edge, the enable held high between.
    task automatic wr_rd(input logic [8:0] a, input logic [15:0] d, input logic [15:0] e);
        @(posedge clk);
        #2;
        en = 1'b1;
        we = 1'b1;
        addr = a;
        di = d;
        @(posedge clk);
        #2;
        we = 1'b0;
        chk({31'h0, rdy}, 32'h1);
        @(posedge clk);
        #2;
        en = 1'b0;
        chk({31'h0, rdy}, 32'h1);
        chk({16'h0, dout}, {16'h0, e});
    endtask

    // Lets the registered settings catch up with the last write.
    task automatic settle();
        @(posedge clk);
        #2;
    endtask

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end

    //--------------------------------------------------------------------------
    // Test sequence
    //--------------------------------------------------------------------------
    // Reset values, then each divider field through all its legal codes.
    initial begin
        en = 1'b0;
        we = 1'b0;
        addr = 9'h000;
        di = 16'h0000;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        #2;
        rstn = 1'b1;
        for (k = 0; k < 9; k++) rd(RA[k], RV[k]);
        for (k = 0; k < 5; k++) begin
            acc(1'b1, 9'h088, 16'hFF88 | {9'h0, k[2:0], 1'b0, 3'(4 - k)});
            rd(9'h088, {9'h0, k[2:0], 1'b0, 3'(4 - k)});
            chk(set.tx_divide, 32'h1 << k);
            chk(set.rx_divide, 32'h1 << (4 - k));
        end
        acc(1'b1, 9'h032, 16'hA5C3);
        wr_rd(9'h033, 16'h87FF, 16'h87FF);
        settle();
        chk(raw.quad_pll_config, {11'h7FF, 16'hA5C3});
        chk(set.quad_pll_lower_band, 32'h1);
        rd(9'h033, 16'h87FF);
        acc(1'b1, 9'h032, 16'hA583);
        settle();
        chk(set.quad_pll_lower_band, 32'h0);
        for (k = 0; k < 4; k++) begin
            acc(1'b1, 9'h033, {QREF[k], 11'h7FF});
            settle();
            chk(set.quad_pll_ref_value, k + 1);
            chk(raw.quad_pll_config[26:16], 32'h7FF);
        end
        for (k = 0; k < 8; k++) begin
            acc(1'b1, 9'h036, {6'h3F, FB[k]});
            acc(1'b1, 9'h037, {9'h1FF, FB[k] != 10'h042, 6'h3F});
            settle();
            chk(set.quad_pll_feedback_value, FB[k]);
            chk(set.quad_setting_error, 32'h0);
            rd(9'h036, {6'h00, FB[k]});
        end
        acc(1'b1, 9'h037, 16'h0000);
        settle();
        chk(set.quad_setting_error, 32'h1);
        for (k = 0; k < 5; k++) begin
            acc(1'b1, 9'h05E, {3'h7, k[0] ? 5'h00 : 5'h10, k[0], CFB[k]});
            settle();
            chk(set.channel_pll_feedback_value, k + 1);
            chk(set.channel_pll_ref_value, k[0] ? 2 : 1);
            chk(set.channel_pll_four_five_factor, k[0] ? 5 : 4);
            chk(set.channel_setting_error, 32'h0);
            rd(9'h05E, {3'h0, k[0] ? 5'h00 : 5'h10, k[0], CFB[k]});
        end
        acc(1'b1, 9'h05E, 16'h0110);
        settle();
        chk(set.channel_setting_error, 32'h1);
        acc(1'b1, 9'h05C, 16'h5AFF);
        acc(1'b1, 9'h05D, 16'h1234);
        settle();
        chk(raw.channel_pll_config, 32'h12345A);
        acc(1'b1, 9'h100, 16'hFFFF);
        rd(9'h100, 16'h0000);
        rd(9'h060, 16'h0000);
        tally_and_finish();
    end
endmodule // pdcm_top_tb
`default_nettype wire
